// *** verilog/xbus_chip_select_config.sv ***
// Expansion bus chip select three decode, mode selection and strobe stretching
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module xbus_chip_select_config (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic standby_power_on_reset_i,
  input wire logic hard_reset_i,
  input wire logic soft_reset_i,
  input wire logic [xbus_cs_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic io_start_i,
  input wire logic [15:0] io_addr_i,
  input wire logic io_write_i,
  output logic lpc_wait_o,
  output logic lpc_done_o,
  output logic expansion_select_three_n_o,
  output logic xbus_read_n_o,
  output logic xbus_write_n_o,
  output logic mode_two_o
);
  import xbus_cs_pkg::*;

  typedef struct packed {
    logic [7:0] base_high;
    logic [5:0] base_low;
    logic protect_cs3;
    logic disable_cs3;
    logic mode2;
    logic [1:0] width_sel;
    logic protect_mode;
    cycle_state_type state;
    logic [2:0] count;
    logic select_n;
    logic read_n;
    logic write_n;
    logic wait_sync;
    logic done;
    logic waitreq;
    logic [7:0] rdata;
  } state_type;

  state_type st;
  state_type next_st;

  logic [15:0] base_addr;
  logic base_valid;
  logic hit;
  logic bus_take;
  logic wr_byte;
  logic [7:0] wdata;
  logic [2:0] width_cycles;
  logic [7:0] low_view;
  logic [7:0] mode_view;

  // Decode of the programmed base against the incoming I/O address
  assign base_addr = {st.base_high, st.base_low, 2'b00};
  assign base_valid = (base_addr >= BASE_MIN) && (base_addr <= BASE_MAX);
  assign hit = !st.mode2 && !st.disable_cs3 && base_valid
    && (io_addr_i[15:2] == base_addr[15:2]);

  // Bus access is taken on the edge where waitrequest is seen low
  assign bus_take = (avs_read_i || avs_write_i) && !st.waitreq;
  assign wr_byte = bus_take && avs_write_i && avs_byteenable_i[0];
  assign wdata = avs_writedata_i[7:0];

  // Register read views, reserved bits forced to zero
  assign low_view = {st.base_low, st.protect_cs3, st.disable_cs3};
  assign mode_view = {st.protect_mode, 3'b000, st.width_sel, 1'b0, st.mode2};

  // Strobe length from the width selection
  always_comb begin
    unique case (st.width_sel)
      2'b00: width_cycles = STROBE_00_CYC;
      2'b01: width_cycles = STROBE_01_CYC;
      2'b10: width_cycles = STROBE_10_CYC;
      2'b11: width_cycles = STROBE_11_CYC;
    endcase
  end

  // Next state of the whole block
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;

    // Bus handshake: one idle cycle with waitrequest high, then one low
    next_st.waitreq = 1'b1;
    if ((avs_read_i || avs_write_i) && st.waitreq) begin
      next_st.waitreq = 1'b0;
      unique case (avs_address_i)
        ADDR_CS3_HIGH: next_st.rdata = st.base_high;
        ADDR_CS3_LOW: next_st.rdata = low_view;
        ADDR_MODE_SEL: next_st.rdata = mode_view;
        default: next_st.rdata = 8'h00;
      endcase
    end

    // Register writes; unmapped addresses are ignored
    if (wr_byte && !st.protect_cs3) begin
      if (avs_address_i == ADDR_CS3_HIGH) begin
        next_st.base_high = wdata;
      end
      if (avs_address_i == ADDR_CS3_LOW) begin
        next_st.base_low = wdata[7:2];
        next_st.disable_cs3 = wdata[LOW_DISABLE_BIT];
        next_st.protect_cs3 = wdata[LOW_PROTECT_BIT];
      end
    end
    if (wr_byte && !st.protect_mode && avs_address_i == ADDR_MODE_SEL) begin
      next_st.mode2 = wdata[MODE_BIT];
      next_st.width_sel = wdata[WIDTH_LSB+:2];
      next_st.protect_mode = wdata[MODE_PROTECT_BIT];
    end

    // Soft reset clears the base registers but keeps the protect bit
    if (soft_reset_i) begin
      next_st.base_high = CS3_HIGH_RESET;
      next_st.base_low = CS3_LOW_RESET[7:2];
      next_st.disable_cs3 = CS3_LOW_RESET[LOW_DISABLE_BIT];
    end

    // Hard and standby resets also drop both protect bits
    if (hard_reset_i || standby_power_on_reset_i) begin
      next_st.base_high = CS3_HIGH_RESET;
      next_st.base_low = CS3_LOW_RESET[7:2];
      next_st.disable_cs3 = CS3_LOW_RESET[LOW_DISABLE_BIT];
      next_st.protect_cs3 = CS3_LOW_RESET[LOW_PROTECT_BIT];
      next_st.protect_mode = MODE_SEL_RESET[MODE_PROTECT_BIT];
    end

    // Only the standby reset returns the mode and width to default
    if (standby_power_on_reset_i) begin
      next_st.mode2 = MODE_SEL_RESET[MODE_BIT];
      next_st.width_sel = MODE_SEL_RESET[WIDTH_LSB+:2];
    end

    // Expansion cycle: select and strobe held for the chosen width
    unique case (st.state)
      CYC_IDLE: begin
        if (io_start_i && hit) begin
          next_st.state = CYC_STROBE;
          next_st.count = width_cycles - 3'd1;
          next_st.select_n = 1'b0;
          next_st.read_n = io_write_i;
          next_st.write_n = !io_write_i;
          next_st.wait_sync = 1'b1;
        end
      end
      CYC_STROBE: begin
        if (st.count == 3'd0) begin
          next_st.state = CYC_IDLE;
          next_st.select_n = 1'b1;
          next_st.read_n = 1'b1;
          next_st.write_n = 1'b1;
          next_st.wait_sync = 1'b0;
          next_st.done = 1'b1;
        end else begin
          next_st.count = st.count - 3'd1;
        end
      end
    endcase
  end

  // State register; the clock enable freezes everything
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      st <= '0;
      st.state <= CYC_IDLE;
      st.select_n <= 1'b1;
      st.read_n <= 1'b1;
      st.write_n <= 1'b1;
      st.waitreq <= 1'b1;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign avs_readdata_o = {24'h000000, st.rdata};
  assign avs_waitrequest_o = st.waitreq;
  assign lpc_wait_o = st.wait_sync;
  assign lpc_done_o = st.done;
  assign expansion_select_three_n_o = st.select_n;
  assign xbus_read_n_o = st.read_n;
  assign xbus_write_n_o = st.write_n;
  assign mode_two_o = st.mode2;

  // Helper: cycles the strobe has been low in the current cycle
  logic [3:0] low_cycles;
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      low_cycles <= 4'h0;
    end else if (ce_i) begin
      if (!st.select_n) begin
        low_cycles <= low_cycles + 4'h1;
      end else begin
        low_cycles <= 4'h0;
      end
    end
  end

  // A hit in mode 1 asserts the select on the next enabled edge
  sel_on_hit_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    ce_i && st.state == CYC_IDLE && io_start_i && hit
    |=> !expansion_select_three_n_o && lpc_wait_o)
    else $error("select not asserted after a matching cycle");

  // A disabled select never asserts
  sel_disabled_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    ce_i && st.state == CYC_IDLE && io_start_i && st.disable_cs3
    |=> expansion_select_three_n_o)
    else $error("disabled select asserted");

  // Mode 2 does not use the base registers
  mode_two_quiet_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    ce_i && st.state == CYC_IDLE && io_start_i && mode_two_o
    |=> expansion_select_three_n_o)
    else $error("select asserted in mode 2");

  // A base outside the permitted window decodes nothing
  base_range_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    ce_i && st.state == CYC_IDLE && io_start_i && !base_valid
    |=> expansion_select_three_n_o)
    else $error("out of range base decoded");

  // Protected base registers ignore a taken write
  base_locked_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    ce_i && st.protect_cs3 && avs_write_i && !avs_waitrequest_o
    && !soft_reset_i && !hard_reset_i && !standby_power_on_reset_i
    |=> $stable(st.base_high) && $stable(st.base_low))
    else $error("protected base register changed");

  // The base protect bit survives soft reset and software writes
  protect_sticky_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    st.protect_cs3 && !hard_reset_i && !standby_power_on_reset_i
    |=> st.protect_cs3)
    else $error("base protect bit cleared");

  // A locked mode register holds mode, width and lock
  mode_locked_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    st.protect_mode && !hard_reset_i && !standby_power_on_reset_i
    |=> st.protect_mode && $stable(st.width_sel) && $stable(mode_two_o))
    else $error("locked mode register changed");

  // A taken mode write updates the mode bit when unlocked
  mode_write_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    ce_i && !st.protect_mode && avs_write_i && !avs_waitrequest_o
    && avs_byteenable_i[0] && avs_address_i == ADDR_MODE_SEL
    && !standby_power_on_reset_i
    |=> mode_two_o == $past(avs_writedata_i[0]))
    else $error("mode bit not written");

  // Reserved mode bits read back as zero
  reserved_zero_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    ce_i && avs_read_i && avs_waitrequest_o && avs_address_i == ADDR_MODE_SEL
    |=> avs_readdata_o[6:4] == 3'b000 && avs_readdata_o[1] == 1'b0)
    else $error("reserved mode bits not zero");

  // The strobe lasts at least the selected width before completion
  strobe_width_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    $rose(lpc_done_o) |-> low_cycles >= {1'b0, width_cycles})
    else $error("strobe shorter than selected width");

  // Wait syncs end only together with completion
  wait_release_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    $fell(lpc_wait_o) |-> lpc_done_o && expansion_select_three_n_o)
    else $error("wait released without completion");

  // Longest width at full enable holds the select six cycles
  long_strobe_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    ce_i && st.state == CYC_IDLE && io_start_i && hit && st.width_sel == 2'b11
    ##1 ce_i [*6]
    |-> !expansion_select_three_n_o && $past(expansion_select_three_n_o, 5) == 1'b0
    ##1 expansion_select_three_n_o)
    else $error("longest strobe not six cycles");

  // Bus answers with waitrequest low for one cycle
  bus_answer_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    ce_i && (avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o ##1 (avs_waitrequest_o || !$past(ce_i)))
    else $error("bus answer timing wrong");

endmodule
`default_nettype wire

// *** verilog/xbus_cs_pkg.sv ***
// Constants for the expansion bus chip select and mode configuration block
package xbus_cs_pkg;
  // Register indices and their Avalon byte addresses (index times four)
  localparam logic [7:0] IDX_CS3_HIGH = 8'h66;
  localparam logic [7:0] IDX_CS3_LOW = 8'h67;
  localparam logic [7:0] IDX_MODE_SEL = 8'hf0;
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] ADDR_CS3_HIGH = {2'h0, IDX_CS3_HIGH, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_CS3_LOW = {2'h0, IDX_CS3_LOW, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_MODE_SEL = {2'h0, IDX_MODE_SEL, 2'h0};

  // Field positions
  localparam int LOW_PROTECT_BIT = 1;
  localparam int LOW_DISABLE_BIT = 0;
  localparam int MODE_BIT = 0;
  localparam int WIDTH_LSB = 2;
  localparam int MODE_PROTECT_BIT = 7;

  // Values after reset
  localparam logic [7:0] CS3_HIGH_RESET = 8'h00;
  localparam logic [7:0] CS3_LOW_RESET = 8'h00;
  localparam logic [7:0] MODE_SEL_RESET = 8'h00;

  // Permitted window for the programmed base (upper nibble must be zero)
  localparam logic [15:0] BASE_MIN = 16'h0100;
  localparam logic [15:0] BASE_MAX = 16'h0ffc;

  // Strobe widths and their cycle counts, least times rounded up
  localparam int CLK_PERIOD_NS = 100;
  localparam int STROBE_00_NS = 180;
  localparam int STROBE_01_NS = 300;
  localparam int STROBE_10_NS = 420;
  localparam int STROBE_11_NS = 540;
  localparam logic [2:0] STROBE_00_CYC = 3'((STROBE_00_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] STROBE_01_CYC = 3'((STROBE_01_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] STROBE_10_CYC = 3'((STROBE_10_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] STROBE_11_CYC = 3'((STROBE_11_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Expansion cycle sequencer states
  typedef enum logic {
    CYC_IDLE,
    CYC_STROBE
  } cycle_state_type;
endpackage

// *** verif/lpc_host_model.sv ***
// Host side model that issues I/O cycles toward the expansion block
`timescale 1ns/1ps
`default_nettype none
module lpc_host_model (
  input wire logic clk_sys_i,
  input wire logic lpc_done_i,
  input wire logic lpc_wait_i,
  input wire logic select_n_i,
  input wire logic read_n_i,
  input wire logic write_n_i,
  output logic io_start_o,
  output logic [15:0] io_addr_o,
  output logic io_write_o
);
  // Idle host: no cycle pending
  initial begin
    io_start_o = 1'b0;
    io_addr_o = 16'h0000;
    io_write_o = 1'b0;
  end

  // One cycle at a time; counts cycles with select, strobe and wait all active
  task automatic io_cycle(input logic [15:0] a, input logic w, output int cnt,
                          output logic done);
    cnt = 0;
    done = 1'b0;
    io_start_o <= 1'b1;
    io_addr_o <= a;
    io_write_o <= w;
    @(posedge clk_sys_i);
    io_start_o <= 1'b0;
    io_addr_o <= ~a; // Released address must not look valid
    io_write_o <= ~w;
    for (int n = 0; n < 12 && !done; n++) begin
      @(posedge clk_sys_i);
      if (!select_n_i && lpc_wait_i && !(w ? write_n_i : read_n_i) && (w ? read_n_i : write_n_i))
        cnt++;
      if (lpc_done_i === 1'b1) done = 1'b1;
    end
  endtask
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench for the expansion bus chip select block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import xbus_cs_pkg::*;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic ce = 1'b1;
  logic [3:0] be = 4'h1;
  logic sby_r = 1'b0, hard_r = 1'b0, soft_r = 1'b0, rd = 1'b0, wr = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [31:0] wdata = '0, rdata;
  logic waitreq, io_start, io_write, lpc_wait, lpc_done, sel_n, rd_n, wr_n, mode2;
  logic [15:0] io_addr;
  int mismatches = 0, num_checks = 0, cycles = 0;

  always #50 clk_sys_i = ~clk_sys_i;

  xbus_chip_select_config xbus_chip_select_config_inst (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .ce_i(ce),
    .standby_power_on_reset_i(sby_r), .hard_reset_i(hard_r), .soft_reset_i(soft_r),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
    .io_start_i(io_start), .io_addr_i(io_addr), .io_write_i(io_write),
    .lpc_wait_o(lpc_wait), .lpc_done_o(lpc_done), .expansion_select_three_n_o(sel_n),
    .xbus_read_n_o(rd_n), .xbus_write_n_o(wr_n), .mode_two_o(mode2));

  lpc_host_model lpc_host_model_inst (
    .clk_sys_i(clk_sys_i), .lpc_done_i(lpc_done), .lpc_wait_i(lpc_wait),
    .select_n_i(sel_n), .read_n_i(rd_n), .write_n_i(wr_n), .io_start_o(io_start),
    .io_addr_o(io_addr), .io_write_o(io_write));

  // Hang guard
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= {24'h0, d};
    do @(posedge clk_sys_i); while (waitreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  task automatic wrt(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [7:0] e, input string name);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    check(name, q, {24'h0, e});
  endtask

  // Sync reset pulse: 0 soft, 1 hard, 2 standby
  task automatic pulse(input int k);
    {sby_r, hard_r, soft_r} <= 3'(1 << k);
    @(posedge clk_sys_i);
    {sby_r, hard_r, soft_r} <= 3'h0;
    @(posedge clk_sys_i);
  endtask

  // I/O cycle with expected active length, zero when it must be ignored
  task automatic cyc(input logic [15:0] a, input logic w, input int n, input string name);
    int cnt;
    logic done;
    lpc_host_model_inst.io_cycle(a, w, cnt, done);
    check(name, 32'(cnt), 32'(n));
    check({name, " done"}, {31'h0, done}, {31'h0, n != 0});
  endtask

  task automatic t_reset_values();
    rdc(ADDR_CS3_HIGH, 8'h00, "high");
    rdc(ADDR_CS3_LOW, 8'h00, "low");
    rdc(ADDR_MODE_SEL, 8'h00, "mode");
    wrt(12'h004, 8'h5a);
    rdc(12'h004, 8'h00, "unmapped");
    be <= 4'h0;
    wrt(ADDR_CS3_HIGH, 8'h11);
    be <= 4'h1;
    rdc(ADDR_CS3_HIGH, 8'h00, "no byte lane");
  endtask

  task automatic t_decode();
    wrt(ADDR_CS3_HIGH, 8'h03); // Upper nibble kept zero
    wrt(ADDR_CS3_LOW, 8'h40);
    rdc(ADDR_CS3_LOW, 8'h40, "low");
    cyc(16'h0342, 1'b0, 2, "match");
    cyc(16'h0344, 1'b1, 0, "miss low");
    cyc(16'h0240, 1'b0, 0, "miss high");
  endtask

  task automatic t_widths();
    int ns [4] = '{180, 300, 420, 540};
    for (int i = 0; i < 4; i++) begin
      wrt(ADDR_MODE_SEL, 8'(i << 2));
      cyc(16'h0340, i[0], (ns[i] + 99) / 100, "width");
    end
  endtask

  task automatic t_mode();
    wrt(ADDR_MODE_SEL, 8'h73); // Host sets up shared pins itself
    rdc(ADDR_MODE_SEL, 8'h01, "reserved");
    check("mode two", {31'h0, mode2}, 32'h1);
    cyc(16'h0340, 1'b0, 0, "mode 2");
    wrt(ADDR_MODE_SEL, 8'h00);
  endtask

  task automatic t_disable_range();
    wrt(ADDR_CS3_LOW, 8'h41);
    cyc(16'h0340, 1'b0, 0, "disabled");
    wrt(ADDR_CS3_HIGH, 8'h00);
    wrt(ADDR_CS3_LOW, 8'h40);
    cyc(16'h0040, 1'b0, 0, "below range");
    wrt(ADDR_CS3_HIGH, 8'h03);
    cyc(16'h0340, 1'b1, 2, "enabled");
  endtask

  task automatic t_protect();
    wrt(ADDR_CS3_LOW, 8'h42);
    wrt(ADDR_CS3_HIGH, 8'h05);
    wrt(ADDR_CS3_LOW, 8'h00);
    rdc(ADDR_CS3_HIGH, 8'h03, "locked high");
    rdc(ADDR_CS3_LOW, 8'h42, "locked low");
    pulse(0);
    rdc(ADDR_CS3_LOW, 8'h02, "soft low");
    pulse(1);
    rdc(ADDR_CS3_LOW, 8'h00, "hard low");
    wrt(ADDR_CS3_HIGH, 8'h07);
    rdc(ADDR_CS3_HIGH, 8'h07, "open high");
  endtask

  task automatic t_mode_lock();
    wrt(ADDR_MODE_SEL, 8'h84);
    wrt(ADDR_MODE_SEL, 8'h00);
    rdc(ADDR_MODE_SEL, 8'h84, "mode locked");
    pulse(0);
    rdc(ADDR_MODE_SEL, 8'h84, "mode soft");
    pulse(1);
    rdc(ADDR_MODE_SEL, 8'h04, "mode hard");
    wrt(ADDR_MODE_SEL, 8'h88);
    pulse(2);
    rdc(ADDR_MODE_SEL, 8'h00, "mode standby");
  endtask

  // Clock enable low freezes state, even against a standby reset
  task automatic t_freeze();
    wrt(ADDR_MODE_SEL, 8'h04);
    ce <= 1'b0;
    pulse(2);
    ce <= 1'b1;
    rdc(ADDR_MODE_SEL, 8'h04, "frozen");
    pulse(2);
    rdc(ADDR_MODE_SEL, 8'h00, "thawed");
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    @(posedge clk_sys_i);
    t_reset_values();
    t_decode();
    t_widths();
    t_mode();
    t_disable_range();
    t_protect();
    t_mode_lock();
    t_freeze();
    report_and_stop();
  end
endmodule
`default_nettype wire
